// ---- rtl/shift5_register.sv ----
/*
 * Five-stage shift register with clear, preset and serial shift.
 * Assumes every input except clk and sys_rst comes from pins outside
 * the clk domain, and that the shift clock is far slower than clk.
 */
// How it works
// - Five chained stages, each with its own visible output.
// - Clear low with no active preset forces all stages low together.
// - Clear acts regardless of the shift clock level or edge.
// - Clear low with all preset inputs low clears, whatever the enable.
// - With clear high, a stage sets when its preset input and the enable are both high.
// - Preset acts regardless of the shift clock level or edge.
// - During preset a stage with low preset input keeps its level.
// - Shifting changes the stages only on a rising shift clock.
// - On a rising edge stage one takes serial in, others the previous.
// - Stages two to five capture stages one to four from before the edge.
`timescale 1ns/1ps
`default_nettype none

module shift5_register
   import shift5_pkg::*;
#(
   parameter int SYNC_STAGES = SYNC_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serial_in,
   input wire logic shiftClk,
   input wire logic clearN,
   input wire logic presetEnable,
   input wire logic presetIn1,
   input wire logic presetIn2,
   input wire logic presetIn3,
   input wire logic presetIn4,
   input wire logic presetIn5,
   output logic stage1_out,
   output logic stage2_out,
   output logic stage3_out,
   output logic stage4_out,
   output logic stage5_out
);

   // The synchroniser depth is fixed by the latency that the outside logic
   // is promised, so any other depth raises an error when simulation starts.
   initial begin
      if (SYNC_STAGES != SYNC_DEPTH) begin
         $error("shift5_register: SYNC_STAGES must equal SYNC_DEPTH.");
      end
   end

   // All state lives in one record: two synchroniser ranks for the pins,
   // the previous synchronised shift clock for edge detection, and the
   // five stages themselves.
   typedef struct packed {
      logic [PIN_COUNT-1:0] syncFirst;
      logic [PIN_COUNT-1:0] syncSecond;
      logic shiftClkPrev;
      logic [STAGE_COUNT-1:0] stages;
   } state_type;

   state_type state_r;
   state_type state_nxt;

   logic [PIN_COUNT-1:0] pinRaw;
   logic serialV;
   logic shiftRise;
   logic clearActive;
   logic [STAGE_COUNT-1:0] presetV;
   logic [STAGE_COUNT-1:0] presetAct;
   logic presetAny;

   // The pins are gathered into one vector so that a single pair of ranks
   // samples them all in the same cycle.
   assign pinRaw = {presetIn5, presetIn4, presetIn3, presetIn2, presetIn1,
                    presetEnable, clearN, shiftClk, serial_in};

   // Only the second synchroniser rank is read by the logic below.
   assign serialV = state_r.syncSecond[PIN_SERIAL];
   assign shiftRise = state_r.syncSecond[PIN_SHIFT_CLK] &
                      ~state_r.shiftClkPrev;
   assign clearActive = ~state_r.syncSecond[PIN_CLEAR_N];
   assign presetV = state_r.syncSecond[PIN_PRESET_LSB +: STAGE_COUNT];
   assign presetAct = presetV &
                      {STAGE_COUNT{state_r.syncSecond[PIN_PRESET_EN]}};
   assign presetAny = |presetAct;

   // Clear and preset are level driven and are looked at every cycle, so
   // they act whatever the shift clock does; a shift edge that meets either
   // of them is dropped, not delayed.
   always_comb begin
      state_nxt = state_r;
      state_nxt.syncFirst = pinRaw;
      state_nxt.syncSecond = state_r.syncFirst;
      state_nxt.shiftClkPrev = state_r.syncSecond[PIN_SHIFT_CLK];
      if (clearActive) begin
         // Clear is level driven and outranks preset and shift.
         state_nxt.stages = STAGE_RESET;
      end else if (presetAny) begin
         // Preset only sets stages; others keep their level.
         state_nxt.stages = state_r.stages | presetAct;
      end else if (shiftRise) begin
         state_nxt.stages[0] = serialV;
         for (int i = 1; i < STAGE_COUNT; i++) begin
            state_nxt.stages[i] = state_r.stages[i-1];
         end
      end
   end

   // The ranks reset low, so clear looks active for two cycles after reset;
   // the stages are already low then, so nothing visible changes.
   // The previous shift clock resets low to match the ranks, which keeps a
   // false edge from appearing after reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r.syncFirst <= PIN_RESET;
         state_r.syncSecond <= PIN_RESET;
         state_r.shiftClkPrev <= SHIFT_CLK_RESET;
         state_r.stages <= STAGE_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Each stage drives its own output straight from its flip-flop.
   assign stage1_out = state_r.stages[0];
   assign stage2_out = state_r.stages[1];
   assign stage3_out = state_r.stages[2];
   assign stage4_out = state_r.stages[3];
   assign stage5_out = state_r.stages[4];

   // The checks below watch the synchronised view of the pins, because that
   // is what the logic acts on; a pin change is seen two cycles later.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_clear_all_low: assert property (
      clearActive |=> state_r.stages == STAGE_RESET)
      else $error("Clear did not force all stages low.");

   a_clear_ignores_clock: assert property (
      clearActive && shiftRise |=> {stage5_out, stage4_out, stage3_out,
         stage2_out, stage1_out} == STAGE_RESET)
      else $error("A shift edge overrode the clear.");

   a_clear_no_preset: assert property (
      clearActive && presetV == STAGE_RESET
      && state_r.syncSecond[PIN_PRESET_EN] |=> ##1 state_r.stages
      == STAGE_RESET || !$past(clearActive))
      else $error("Clear with idle preset inputs left a stage high.");

   a_preset_sets: assert property (
      !clearActive && presetAny |=>
         (state_r.stages & $past(presetAct)) == $past(presetAct))
      else $error("An enabled preset input did not set its stage.");

   a_preset_ignores_clock: assert property (
      !clearActive && presetAny && shiftRise |=>
         state_r.stages == ($past(state_r.stages) | $past(presetAct)))
      else $error("A shift edge disturbed the preset.");

   a_preset_keeps: assert property (
      !clearActive && presetAny |=> (state_r.stages & ~$past(presetAct))
         == ($past(state_r.stages) & ~$past(presetAct)))
      else $error("Preset changed a stage whose preset input was low.");

   a_hold_no_edge: assert property (
      !clearActive && !presetAny && !shiftRise |=> $stable(state_r.stages))
      else $error("Stages moved without a rising shift clock.");

   a_shift_first: assert property (
      !clearActive && !presetAny && shiftRise |=>
         stage1_out == $past(serialV))
      else $error("Stage one did not take the serial input.");

   a_shift_chain: assert property (
      !clearActive && !presetAny && shiftRise |=>
         state_r.stages[STAGE_COUNT-1:1] ==
         $past(state_r.stages[STAGE_COUNT-2:0]))
      else $error("Later stages did not take the previous stage levels.");

   a_clear_wins: assert property (
      clearActive && presetAny |=> state_r.stages == STAGE_RESET)
      else $error("Preset won over clear.");

   // The edge detector must give exactly one pulse per rising shift clock.
   // A pulse that lasted two cycles would shift the chain twice for one
   // edge and lose a bit.
   a_rise_single: assert property (
      shiftRise |=> !shiftRise)
      else $error("Shift edge detector stayed high for two cycles.");

   // Without clear, preset or a shift edge the visible outputs hold.
   // This watches the ports rather than the state record, so a broken
   // output wiring is caught as well.
   a_outs_hold: assert property (
      !clearActive && !presetAny && !shiftRise |=>
         {stage5_out, stage4_out, stage3_out, stage2_out, stage1_out}
         == $past(state_r.stages))
      else $error("Outputs moved without a rising shift clock.");

   // Preset only ever sets stages; no stage may fall while it is applied.
   // A stage falling here would mean preset was wired as a load.
   // Clear is excluded because it outranks preset.
   a_preset_no_fall: assert property (
      !clearActive && presetAny |=>
         ($past(state_r.stages) & ~state_r.stages) == STAGE_RESET)
      else $error("A stage fell during preset.");

   // A clear held over several cycles keeps every stage low throughout.
   // This guards against a clear that acts only on its first cycle.
   // The outside logic may hold clear for as long as it likes.
   a_clear_stays_low: assert property (
      clearActive ##1 clearActive |=> state_r.stages == STAGE_RESET)
      else $error("A held clear let a stage rise.");

   // With clear, preset and a shift edge all at once, clear still wins.
   // This is the full priority case: clear over preset over shift.
   // It can only arise when the outside logic breaks its own rules.
   a_clear_beats_all: assert property (
      clearActive && presetAny && shiftRise |=>
         state_r.stages == STAGE_RESET)
      else $error("Clear lost against preset and shift together.");

   // Preset outranks a shift edge: stage one keeps its level or is set,
   // but never takes the serial input while preset is applied.
   // The shift edge in that cycle is dropped.
   a_preset_beats_shift: assert property (
      !clearActive && presetAny && shiftRise |=>
         stage1_out == ($past(presetAct[0]) | $past(state_r.stages[0])))
      else $error("A shift edge won over preset.");

   // Stage one only follows the serial input on a shift edge.
   // A serial input that leaks straight through would show up here.
   // Clear and preset are excluded since they move the stage themselves.
   a_first_hold: assert property (
      !clearActive && !presetAny && !shiftRise |=>
         stage1_out == $past(stage1_out))
      else $error("Stage one moved without a shift edge.");

   // Clear must act while the shift clock stands high, not only while it
   // stands low: its action does not depend on the clock level.
   // Both levels are checked by this and by the clear check above.
   a_clear_high_clock: assert property (
      clearActive && state_r.syncSecond[PIN_SHIFT_CLK] |=>
         state_r.stages == STAGE_RESET)
      else $error("Clear failed while the shift clock was high.");

   // Preset must act while the shift clock stands high as well.
   // The set bits are checked; the other bits are covered by the
   // keep check above.
   a_preset_high_clock: assert property (
      !clearActive && presetAny && state_r.syncSecond[PIN_SHIFT_CLK] |=>
         (state_r.stages & $past(presetAct)) == $past(presetAct))
      else $error("Preset failed while the shift clock was high.");

   // With the enable low, the preset inputs alone must not set anything.
   // Only a shift edge or a clear may then move the stages.
   // This guards the gating of the preset inputs by the enable.
   a_enable_gates: assert property (
      !clearActive && !state_r.syncSecond[PIN_PRESET_EN] && !shiftRise
         |=> $stable(state_r.stages))
      else $error("A preset input set a stage with the enable low.");

   // Per-stage checks of the chain and of the preset set path.
   // Each later stage takes its predecessor on a shift edge, and stages
   // two to five are each set by their own enabled preset input.
   for (genvar g = 1; g < STAGE_COUNT; g++) begin : g_stage_checks
      a_stage_follows: assert property (
         !clearActive && !presetAny && shiftRise |=>
            state_r.stages[g] == $past(state_r.stages[g-1]))
         else $error("A stage did not take the level before it.");

      a_stage_set: assert property (
         !clearActive && presetAct[g] |=> state_r.stages[g])
         else $error("An enabled preset input left its stage low.");
   end

endmodule // shift5_register

`default_nettype wire

// ---- common/shift5_pkg.sv ----
/*
 * Constants shared by the five-stage shift register.
 * Assumes nothing of its surroundings; it is compiled before the design.
 */
`default_nettype none

package shift5_pkg;

   // Number of chained storage stages.
   localparam int STAGE_COUNT = 5;

   // Depth of the input synchronisers that face the pins.
   localparam int SYNC_DEPTH = 2;

   // Bit positions of the sampled pin vector.
   localparam int PIN_SERIAL = 0;
   localparam int PIN_SHIFT_CLK = 1;
   localparam int PIN_CLEAR_N = 2;
   localparam int PIN_PRESET_EN = 3;
   localparam int PIN_PRESET_LSB = 4;
   localparam int PIN_COUNT = PIN_PRESET_LSB + STAGE_COUNT;

   // Values taken by the state at reset.
   localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 5'h00;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 9'h000;
   localparam logic SHIFT_CLK_RESET = 1'h0;

endpackage

`default_nettype wire

// ---- sim/shift_driver.sv ----
/*
 * Behavioural model of the logic that drives the shift register pins.
 * Assumes it shares clk with the block and that the bench calls its tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module shift_driver
   import shift5_pkg::*;
(
   input wire logic clk,
   output logic serialIn,
   output logic shiftClk,
   output logic clearN,
   output logic presetEnable,
   output logic [STAGE_COUNT-1:0] presetBus
);
   initial begin
      serialIn = 1'b0;
      shiftClk = 1'b0;
      clearN = 1'b1;
      presetEnable = 1'b0;
      presetBus = 5'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic drive(input logic clr, input logic en,
                        input logic [STAGE_COUNT-1:0] bus);
      @(posedge clk);
      clearN <= clr;
      presetEnable <= en;
      presetBus <= bus;
   endtask

   // The preset path stays as the caller left it while the clock rises.
   task automatic shift_one(input logic bitVal);
      @(posedge clk);
      serialIn <= bitVal;
      tick(3);
      shiftClk <= 1'b1;
      tick(3);
      shiftClk <= 1'b0;
      serialIn <= ~bitVal;
      tick(3);
   endtask

   // Clear first, present the word, then pulse the enable.
   task automatic load(input logic [STAGE_COUNT-1:0] word);
      drive(1'b0, 1'b0, 5'h00);
      tick(4);
      drive(1'b1, 1'b0, word);
      drive(1'b1, 1'b1, word);
      tick(4);
      drive(1'b1, 1'b0, 5'h00);
      tick(4);
   endtask
endmodule // shift_driver

`default_nettype wire

// ---- sim/test_shift5_register.sv ----
/*
 * Self-checking bench for the five-stage shift register.
 * Assumes the pin driver model and the package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_shift5_register;
   import shift5_pkg::*;
   logic clk, sysRst, serialIn, shiftClk, clearN, presetEnable;
   logic [4:0] presetBus, stages;
   int numErrors = 0;
   int checks = 0;

   shift_driver shift_driver_i (.clk(clk), .serialIn(serialIn),
      .shiftClk(shiftClk), .clearN(clearN), .presetEnable(presetEnable),
      .presetBus(presetBus));
   shift5_register shift5_register_i (.clk(clk), .sys_rst(sysRst),
      .serial_in(serialIn), .shiftClk(shiftClk), .clearN(clearN),
      .presetEnable(presetEnable), .presetIn1(presetBus[0]),
      .presetIn2(presetBus[1]), .presetIn3(presetBus[2]),
      .presetIn4(presetBus[3]), .presetIn5(presetBus[4]),
      .stage1_out(stages[0]), .stage2_out(stages[1]),
      .stage3_out(stages[2]), .stage4_out(stages[3]),
      .stage5_out(stages[4]));

   task automatic give_verdict();
      if (numErrors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check_stages(input logic [4:0] exp);
      #1;
      checks++;
      if (stages !== exp) begin
         numErrors++;
         $display("Error stages expected %h seen %h", exp, stages);
      end
   endtask

   task automatic test_load();
      shift_driver_i.load(5'h15);
      check_stages(5'h15);
      shift_driver_i.drive(1'b1, 1'b1, 5'h0A);
      shift_driver_i.tick(5);
      check_stages(5'h1F);
      shift_driver_i.drive(1'b1, 1'b0, 5'h00);
      shift_driver_i.tick(4);
   endtask

   task automatic test_shift();
      logic [4:0] exp;
      logic [4:0] pattern;
      exp = 5'h1F;
      pattern = 5'h12;
      for (int i = 0; i < STAGE_COUNT; i++) begin
         shift_driver_i.shift_one(pattern[i]);
         exp = {exp[3:0], pattern[i]};
         check_stages(exp);
      end
   endtask

   task automatic test_clear();
      shift_driver_i.drive(1'b0, 1'b1, 5'h1F);
      shift_driver_i.tick(5);
      check_stages(5'h00);
      shift_driver_i.drive(1'b0, 1'b1, 5'h00);
      shift_driver_i.shift_one(1'b1);
      check_stages(5'h00);
      shift_driver_i.drive(1'b1, 1'b1, 5'h00);
      shift_driver_i.shift_one(1'b1);
      check_stages(5'h01);
      shift_driver_i.drive(1'b1, 1'b1, 5'h04);
      shift_driver_i.shift_one(1'b1);
      check_stages(5'h05);
      shift_driver_i.drive(1'b0, 1'b1, 5'h00);
      shift_driver_i.tick(5);
      check_stages(5'h00);
   endtask

   task automatic test_reset();
      shift_driver_i.drive(1'b1, 1'b0, 5'h00);
      shift_driver_i.shift_one(1'b1);
      check_stages(5'h01);
      @(posedge clk);
      sysRst <= 1'b1;
      repeat (3) @(posedge clk);
      sysRst <= 1'b0;
      repeat (4) @(posedge clk);
      check_stages(5'h00);
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      sysRst <= 1'b1;
      repeat (12) @(posedge clk);
      sysRst <= 1'b0;
      repeat (4) @(posedge clk);
      check_stages(5'h00);
      test_load();
      test_shift();
      test_clear();
      test_reset();
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk);
      numErrors++;
      give_verdict();
   end
endmodule // test_shift5_register

`default_nettype wire
